//--- sample_timing_pkg.sv
package sample_timing_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] REG_TIMING_SEL_OFS = 8'h00;
  localparam logic [7:0] REG_MODE_CTRL_OFS  = 8'h02;
  localparam logic [7:0] REG_AUX_CTRL_OFS   = 8'h04;
  localparam logic [7:0] REG_PHASE_CFG_OFS  = 8'h06;
  localparam logic [7:0] REG_STATUS_OFS     = 8'h08;

  // Field positions
  localparam int TIMING_DOUBLE_BIT = 0;
  localparam int MODE_STROBE_BIT   = 7;
  localparam int MODE_GATED_BIT    = 1;
  localparam int AUX_SYNC_EDGE_BIT = 5;
  localparam int AUX_SYNC_MODE_BIT = 1;
  localparam int PHASE_SIX_CH_BIT  = 0;
  localparam int PHASE_SEL_LSB     = 1;
  localparam int PHASE_SEL_MSB     = 2;
  localparam int STAT_MODE_LSB     = 0;
  localparam int STAT_MODE_MSB     = 2;
  localparam int STAT_PHASE_BIT    = 3;
  localparam int STAT_PULSE_BIT    = 4;
  localparam int STAT_SYNC_BIT     = 5;

  // Reset values: self-phased hold mode, six channels, phase select 11
  localparam logic [7:0] TIMING_SEL_RST = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST  = 8'h80;
  localparam logic [7:0] AUX_CTRL_RST   = 8'h00;
  localparam logic [7:0] PHASE_CFG_RST  = 8'h07;
  localparam logic [1:0] PHASE_SEL_RST  = 2'h3;

  // Input timing modes
  typedef enum logic [2:0] {
    self_phased_hold_mode,
    direct_hold_mode,
    phase_generated_hold_mode,
    strobe_gated_hold_mode,
    phase_generated_double_sample_mode,
    strobe_gated_double_sample_mode,
    invalid_mode
  } mode_t;

endpackage

//--- phase_generator.sv
`timescale 1ns/100ps
module phase_generator (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       six_channel,
  input  wire logic [1:0] phase_select_field,
  input  wire logic       sync_align,
  input  wire logic       hold_align,
  output logic            internal_phase_signal,
  output logic            pixel_phase
);

  logic ph_r;
  logic ph_nxt;
  logic ph_n_r;

  // Pixel phase toggles once per master clock; realign pulses override the toggle
  always_comb begin
    ph_nxt = ~ph_r;
    if (sync_align) begin
      ph_nxt = 1'b0;
    end else if (hold_align) begin
      ph_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  // Falling-edge copy gives the half-clock step needed for quarter-pixel shifts
  always_ff @(negedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_n_r <= 1'b0;
    end else begin
      ph_n_r <= ph_r;
    end
  end

  // Phase choice: four shifts with six channels, two with three channels
  always_comb begin
    internal_phase_signal = ph_r;
    if (six_channel) begin
      case (phase_select_field)
        2'h3:    internal_phase_signal = ph_r;
        2'h2:    internal_phase_signal = ~ph_n_r;
        2'h1:    internal_phase_signal = ~ph_r;
        2'h0:    internal_phase_signal = ph_n_r;
        default: internal_phase_signal = ph_r;
      endcase
    end else begin
      // Only the low select bit counts here; set, the high half is the clock's first half, clear, the second half
      internal_phase_signal = phase_select_field[0] ? (ph_r ^ ph_n_r)
                                                    : ~(ph_r ^ ph_n_r);
    end
  end

  assign pixel_phase = ph_r;

endmodule

//--- sample_timing_control.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module sample_timing_control (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       line_sync_in,
  input  wire logic       reference_strobe,
  input  wire logic       signal_strobe,
  input  wire logic       sample_in,
  input  wire logic       hold_in,
  output logic            clamp_strobe,
  output logic            sample_strobe,
  output logic            stage_sample,
  output logic            stage_hold,
  output logic            internal_phase_signal
);

  logic [7:0] timing_sel_r;
  logic [7:0] mode_ctrl_r;
  logic [7:0] aux_ctrl_r;
  logic [7:0] phase_cfg_r;
  logic [7:0] rdata_nxt;

  logic       sync_rise_r;
  logic       sync_fall_r;
  logic       sync_level;
  logic       sync_prev_r;
  logic       sync_align;
  logic       sample_prev_r;
  logic       hold_prev_r;
  logic       sample_rise;
  logic       hold_rise;
  logic       hold_align;
  logic       sh_pulse_r;
  logic       stage_sample_r;
  logic       stage_hold_r;
  logic       pixel_phase;

  sample_timing_pkg::mode_t mode;

  // Four-bit mode decode shared by the strobe logic and the status readback
  function automatic sample_timing_pkg::mode_t decode_mode(input logic [3:0] sel);
    sample_timing_pkg::mode_t m;
    m = sample_timing_pkg::invalid_mode;
    case (sel)
      4'h4:    m = sample_timing_pkg::self_phased_hold_mode;
      4'hc:    m = sample_timing_pkg::direct_hold_mode;
      4'ha:    m = sample_timing_pkg::phase_generated_hold_mode;
      4'he:    m = sample_timing_pkg::strobe_gated_hold_mode;
      4'hb:    m = sample_timing_pkg::phase_generated_double_sample_mode;
      4'hf:    m = sample_timing_pkg::strobe_gated_double_sample_mode;
      default: m = sample_timing_pkg::invalid_mode;
    endcase
    return m;
  endfunction

  assign mode = decode_mode({aux_ctrl_r[sample_timing_pkg::AUX_SYNC_MODE_BIT],
                             mode_ctrl_r[sample_timing_pkg::MODE_STROBE_BIT],
                             mode_ctrl_r[sample_timing_pkg::MODE_GATED_BIT],
                             timing_sel_r[sample_timing_pkg::TIMING_DOUBLE_BIT]});

  // Register writes; reset values put the block in self-phased hold with phase 11
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      timing_sel_r <= sample_timing_pkg::TIMING_SEL_RST;
      mode_ctrl_r  <= sample_timing_pkg::MODE_CTRL_RST;
      aux_ctrl_r   <= sample_timing_pkg::AUX_CTRL_RST;
      phase_cfg_r  <= sample_timing_pkg::PHASE_CFG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        sample_timing_pkg::REG_TIMING_SEL_OFS: timing_sel_r <= reg_wdata;
        sample_timing_pkg::REG_MODE_CTRL_OFS:  mode_ctrl_r  <= reg_wdata;
        sample_timing_pkg::REG_AUX_CTRL_OFS:   aux_ctrl_r   <= reg_wdata;
        sample_timing_pkg::REG_PHASE_CFG_OFS:  phase_cfg_r  <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      sample_timing_pkg::REG_TIMING_SEL_OFS: rdata_nxt = timing_sel_r;
      sample_timing_pkg::REG_MODE_CTRL_OFS:  rdata_nxt = mode_ctrl_r;
      sample_timing_pkg::REG_AUX_CTRL_OFS:   rdata_nxt = aux_ctrl_r;
      sample_timing_pkg::REG_PHASE_CFG_OFS:  rdata_nxt = phase_cfg_r;
      sample_timing_pkg::REG_STATUS_OFS: begin
        rdata_nxt[sample_timing_pkg::STAT_MODE_MSB:sample_timing_pkg::STAT_MODE_LSB] = mode;
        rdata_nxt[sample_timing_pkg::STAT_PHASE_BIT] = pixel_phase;
        rdata_nxt[sample_timing_pkg::STAT_PULSE_BIT] = sh_pulse_r;
        rdata_nxt[sample_timing_pkg::STAT_SYNC_BIT]  = sync_prev_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data holds for exactly the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Line sync caught on both edges so software can pick whichever meets setup
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_rise_r <= 1'b0;
    end else begin
      sync_rise_r <= line_sync_in;
    end
  end

  always_ff @(negedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_fall_r <= 1'b0;
    end else begin
      sync_fall_r <= line_sync_in;
    end
  end

  assign sync_level = aux_ctrl_r[sample_timing_pkg::AUX_SYNC_EDGE_BIT] ? sync_fall_r
                                                                       : sync_rise_r;

  // Edge history for line sync and the sample/hold inputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_prev_r   <= 1'b0;
      sample_prev_r <= 1'b0;
      hold_prev_r   <= 1'b0;
    end else begin
      sync_prev_r   <= sync_level;
      sample_prev_r <= sample_in;
      hold_prev_r   <= hold_in;
    end
  end

  // A narrow sync shorter than one clock may be missed; the host keeps it wider
  assign sync_align = sync_level && !sync_prev_r &&
                      (mode != sample_timing_pkg::self_phased_hold_mode);

  assign sample_rise = sample_in && !sample_prev_r;
  assign hold_rise   = hold_in && !hold_prev_r;
  assign hold_align  = hold_rise &&
                       (mode == sample_timing_pkg::self_phased_hold_mode);

  phase_generator u_phase (
    .ref_clk               (ref_clk),
    .arst_n                (arst_n),
    .six_channel           (phase_cfg_r[sample_timing_pkg::PHASE_SIX_CH_BIT]),
    .phase_select_field    (phase_cfg_r[sample_timing_pkg::PHASE_SEL_MSB:
                                        sample_timing_pkg::PHASE_SEL_LSB]),
    .sync_align            (sync_align),
    .hold_align            (hold_align),
    .internal_phase_signal (internal_phase_signal),
    .pixel_phase           (pixel_phase)
  );

  // Acquisition window: opens on sample rise, closes on hold rise; hold wins a tie
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_pulse_r <= 1'b0;
    end else if (hold_rise) begin
      sh_pulse_r <= 1'b0;
    end else if (sample_rise) begin
      sh_pulse_r <= 1'b1;
    end
  end

  // First-stage controls follow the pins in direct and self-phased hold, low otherwise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_sample_r <= 1'b0;
      stage_hold_r   <= 1'b0;
    end else if ((mode == sample_timing_pkg::direct_hold_mode) ||
                 (mode == sample_timing_pkg::self_phased_hold_mode)) begin
      stage_sample_r <= sample_in;
      stage_hold_r   <= hold_in;
    end else begin
      stage_sample_r <= 1'b0;
      stage_hold_r   <= 1'b0;
    end
  end

  assign stage_sample = stage_sample_r;
  assign stage_hold   = stage_hold_r;

  // Internal strobes; kept combinational so they keep sub-clock phase resolution
  always_comb begin
    clamp_strobe  = 1'b0;
    sample_strobe = 1'b0;
    case (mode)
      sample_timing_pkg::phase_generated_hold_mode: begin
        sample_strobe = ~internal_phase_signal;
      end
      sample_timing_pkg::phase_generated_double_sample_mode: begin
        clamp_strobe  = internal_phase_signal;
        sample_strobe = ~internal_phase_signal;
      end
      sample_timing_pkg::strobe_gated_hold_mode: begin
        sample_strobe = signal_strobe & ~internal_phase_signal;
      end
      sample_timing_pkg::strobe_gated_double_sample_mode: begin
        clamp_strobe  = reference_strobe & internal_phase_signal;
        sample_strobe = signal_strobe & ~internal_phase_signal;
      end
      sample_timing_pkg::direct_hold_mode,
      sample_timing_pkg::self_phased_hold_mode: begin
        sample_strobe = sh_pulse_r & ~internal_phase_signal;
      end
      default: begin
        clamp_strobe  = 1'b0;
        sample_strobe = 1'b0;
      end
    endcase
  end

endmodule

//--- host_timing_model.sv
`timescale 1ns/100ps
module host_timing_model (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic rnd_en,
  input  wire logic sync_req,
  input  wire logic hold_req,
  output logic      line_sync_in,
  output logic      reference_strobe,
  output logic      signal_strobe,
  output logic      sample_in,
  output logic      hold_in
);
  integer     seed = 32'hc0d3;
  logic [2:0] ls_r;
  logic [3:0] rnd;
  // Line sync pulse counter; the caller spaces requests so the low time also lasts
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      ls_r <= 3'h0;
    else if (sync_req)
      ls_r <= 3'h4;
    else if (ls_r != 3'h0)
      ls_r <= ls_r - 3'h1;
  end
  assign line_sync_in = (ls_r > 3'h2);
  // Random strobes; all quiet in reset so nothing leaks into the first cycle
  always @(posedge ref_clk) begin
    rnd = $random(seed);
    reference_strobe <= arst_n & rnd_en & rnd[0];
    signal_strobe <= arst_n & rnd_en & rnd[1];
    sample_in <= arst_n & rnd_en & rnd[2];
    hold_in <= arst_n & (hold_req | (rnd_en & rnd[3]));
  end
endmodule

//--- sample_timing_control_sva.sv
`timescale 1ns/100ps
module sample_timing_control_sva (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reference_strobe,
  input wire logic       signal_strobe,
  input wire logic       sample_in,
  input wire logic       hold_in,
  input wire logic       clamp_strobe,
  input wire logic       sample_strobe,
  input wire logic       stage_sample,
  input wire logic       stage_hold,
  input wire logic       internal_phase_signal
);
  logic [3:0] mode_r;
  // Mirror of the four mode bits as software writes them
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= 4'h4;
    end else if (reg_wr) begin
      if (reg_addr == 8'h04)
        mode_r[3] <= reg_wdata[1];
      if (reg_addr == 8'h02)
        mode_r[2:1] <= {reg_wdata[7], reg_wdata[1]};
      if (reg_addr == 8'h00)
        mode_r[0] <= reg_wdata[0];
    end
  end
  wire hs  = (mode_r[2:0] == 3'h4);
  wire sg  = (mode_r[3:1] == 3'h7);
  wire bad = !(mode_r inside {4'h4, 4'hc, 4'ha, 4'he, 4'hb, 4'hf});
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_clamp_phase: assert property (clamp_strobe |-> internal_phase_signal)
    else $error("clamp outside phase high");
  chk_sample_phase: assert property (sample_strobe |-> !internal_phase_signal)
    else $error("sample outside phase low");
  chk_gated_sample: assert property (sg |-> sample_strobe == (signal_strobe && !internal_phase_signal))
    else $error("gated sample wrong");
  chk_gated_clamp: assert property (mode_r == 4'hf |-> clamp_strobe == (reference_strobe && internal_phase_signal))
    else $error("gated clamp wrong");
  chk_no_ref: assert property (!mode_r[0] |-> !clamp_strobe)
    else $error("clamp without double sampling");
  chk_stage_sample: assert property (stage_sample == ($past(hs) && $past(sample_in)))
    else $error("stage sample wrong");
  chk_stage_hold: assert property (stage_hold == ($past(hs) && $past(hold_in)))
    else $error("stage hold wrong");
  chk_bad_quiet: assert property (bad |-> !clamp_strobe && !sample_strobe)
    else $error("strobe in invalid mode");
  cov_gated_clamp: cover property (mode_r == 4'hf && clamp_strobe);
  cov_stage: cover property (hs && $rose(stage_sample));
  cov_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind sample_timing_control sample_timing_control_sva chk_u (.ref_clk, .arst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reference_strobe, .signal_strobe, .sample_in,
  .hold_in, .clamp_strobe, .sample_strobe, .stage_sample, .stage_hold, .internal_phase_signal);

//--- test_sample_timing_control.sv
`timescale 1ns/100ps
module test_sample_timing_control;
  logic        ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        rnd_en = 1'b0, sync_req = 1'b0, hold_req = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        line_sync_in, reference_strobe, signal_strobe, sample_in, hold_in;
  logic        clamp_strobe, sample_strobe, stage_sample, stage_hold, internal_phase_signal;
  logic        ps, ph, p, pps, pph;
  logic        w = 1'b0;
  logic [11:0] h, ref_h;
  logic [3:0]  modes [7] = '{4'h4, 4'hc, 4'ha, 4'he, 4'hb, 4'hf, 4'h0};
  logic [7:0]  ra [5] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h0a};
  logic [7:0]  rv [5] = '{8'h00, 8'h80, 8'h00, 8'h07, 8'h00};
  integer      miscompares = 0, checked = 0;
  // Converter-rate master clock
  initial forever #2 ref_clk = ~ref_clk;
  sample_timing_control dut_u (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .line_sync_in, .reference_strobe, .signal_strobe, .sample_in, .hold_in,
    .clamp_strobe, .sample_strobe, .stage_sample, .stage_hold, .internal_phase_signal);
  host_timing_model host_u (.ref_clk, .arst_n, .rnd_en, .sync_req, .hold_req, .line_sync_in,
    .reference_strobe, .signal_strobe, .sample_in, .hold_in);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Mask keeps live status bits (phase, window, sync) out of a mode-code compare
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk = 8'hff);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & msk, exp);
  endtask
  task automatic set_mode(input logic [3:0] m);
    wr(8'h04, {6'h00, m[3], 1'b0});
    wr(8'h02, {m[2], 5'h00, m[1], 1'b0});
    wr(8'h00, {7'h00, m[0]});
  endtask
  // Request an alignment edge, then record the phase after each clock edge
  task automatic align(input logic use_hold, input int extra);
    repeat (extra) @(posedge ref_clk);
    sync_req <= !use_hold;
    hold_req <= use_hold;
    @(posedge ref_clk);
    sync_req <= 1'b0;
    hold_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int n = 0; n < 12; n++) begin
      if (n[0])
        @(negedge ref_clk);
      else
        @(posedge ref_clk);
      #1 h[n] = internal_phase_signal;
    end
  endtask
  // Hangs end here well after the expected few hundred cycles
  initial begin
    #20000;
    miscompares = miscompares + 1;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 5; k++)
      rd(ra[k], rv[k]);
    // The six mode codes and invalid code 0, random strobes each cycle; sample strobe not compared in codes a and b
    for (int i = 0; i < 7; i++) begin
      set_mode(modes[i]);
      rd(8'h00, {7'h00, modes[i][0]});
      rd(8'h08, {5'h00, 3'(i)}, 8'h07);
      rnd_en <= 1'b1;
      @(posedge ref_clk);
      #1 ps = sample_in;
      ph = hold_in;
      pps = 1'b0;
      pph = 1'b0;
      repeat (16) begin
        @(posedge ref_clk);
        #1 p = internal_phase_signal;
        // Window model: hold rise closes, sample rise opens, hold wins a tie
        w = (ph & !pph) ? 1'b0 : (ps & !pps) ? 1'b1 : w;
        chk(stage_sample, (i < 2) & ps);
        chk(stage_hold, (i < 2) & ph);
        chk(clamp_strobe, (i == 5) ? reference_strobe & p : (i == 4) ? p : 1'b0);
        if (i == 3 || i >= 5)
          chk(sample_strobe, (i < 6) & signal_strobe & !p);
        if (i < 2)
          chk(sample_strobe, w & !p);
        pps = ps;
        pph = ph;
        ps = sample_in;
        ph = hold_in;
      end
      rnd_en <= 1'b0;
      // The last random pins still reach the window at the next edge
      @(posedge ref_clk);
      #1 w = (ph & !pph) ? 1'b0 : (ps & !pps) ? 1'b1 : w;
    end
    // Six channels: each select shifts the line-synced phase by quarter pixels
    set_mode(4'hc);
    for (int s = 3; s >= 0; s--) begin
      wr(8'h06, {5'h00, s[1:0], 1'b1});
      align(1'b0, s);
      if (s == 3)
        ref_h = h;
      for (int n = 0; n < 8; n++) begin
        chk(h[n], ref_h[n + 3 - s]);
        if (s == 3)
          chk(h[n + 2], !h[n]);
      end
    end
    // Falling-edge capture of line sync aligns one clock earlier
    wr(8'h04, 8'h22);
    wr(8'h06, 8'h07);
    align(1'b0, 1);
    for (int n = 0; n < 8; n++)
      chk(h[n], ref_h[n + 2]);
    // Self-phased hold: hold edges align, line sync is ignored
    set_mode(4'h4);
    wr(8'h06, 8'h07);
    align(1'b1, 0);
    ref_h = h;
    align(1'b1, 0);
    chk(h[7:0], ref_h[7:0]);
    align(1'b0, 0);
    chk(h[7:0], ~ref_h[7:0]);
    // Three channels: two choices, the high select bit has no effect
    set_mode(4'hc);
    for (int s = 0; s < 4; s++) begin
      wr(8'h06, {5'h00, s[1:0], 1'b0});
      align(1'b0, 0);
      for (int n = 0; n < 8; n++)
        chk(h[n], n[0] ^ s[0]);
    end
    // A second reset brings the select back to its default
    wr(8'h06, 8'h00);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(8'h06, 8'h07);
    print_verdict();
  end
endmodule
